// File: rtl/gate_driver_fault_supervisor.sv
// Behaviour
// RL1: Undervoltage threshold picked from mosfet level and threshold select bits.
// RL2: Pump undervoltage while enabled actively turns off on MOSFETs for cross-current time.
// RL3: Then gate drivers go off and pump undervoltage flag latches; code does both on detection, when active turn-off starts.
// RL4: Flag clears, operation resumes after status clear and pump above threshold.
// RL5: Undervoltage detection blanked at each pump activation or supply recovery.
// RL6: Switching reports show active MOSFETs when check select is 1, else PWM MOSFET.
// RL7: Low-sides on for sudden-stop with PWM high and parking in sleep while pump off, and for overvoltage.
// RL8: Braking threshold select picks first or second drain-source threshold.
// RL9: Brake start launches short or long blank time masking low-side overvoltage.
// RL10: Braking overvoltage reported only after fixed filter time.
// RL11: Braking overvoltage latches all low-sides off, sets per-side fault, config untouched.
// RL12: Low-sides stay blocked until all braking faults cleared, even if side disabled.
// RL13: Pump enable accepted during braking fault but pump stays off until cleared.
// RL14: Overvoltage braking applies in every mode when its enable bit is set.
// RL15: Supply overvoltage turns on all low-sides and latches the matching flag.
// RL16: Both supplies below falling level for filter time ends overvoltage braking.
// RL17: Low-side overvoltage during overvoltage braking turns all low-sides off after filter.
// RL18: All blank, filter and hold times are clocked counters from named durations.
`include "gds_params.svh"

module gate_driver_fault_supervisor (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        pump_uv_cmp_i,
    input  wire logic [1:0]  lowside_vds_cmp_i,
    input  wire logic        supply_ov_cmp_i,
    input  wire logic        internal_ov_cmp_i,
    input  wire logic        supply_ov_low_i,
    input  wire logic        internal_ov_low_i,
    input  wire logic        pwm_input_pin_i,
    input  wire logic        low_power_mode_i,
    input  wire logic        supply_recovery_i,
    input  wire logic        gates_on_i,
    input  wire logic [31:0] meas_active_i,
    input  wire logic [31:0] meas_pwm_i,
    output logic [1:0]       pump_uv_level_o,
    output logic             pump_on_o,
    output logic             active_off_o,
    output logic             drivers_enable_o,
    output logic [1:0]       lowside_on_o,
    output logic             brake_threshold_o,
    output logic [2:0]       ov_brake_config_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts
    // Durations round up to whole clocks and never fall below one cycle,
    // so a very short time still masks or filters at least one sample.
    // Counter width limits the longest time to 1023 cycles.

    localparam logic [`CNT_W-1:0] CCP_CYC   = `CNT_W'(`NS_TO_CYC(`T_CCP_NS));  // [RL18]
    localparam logic [`CNT_W-1:0] CPUV_CYC  = `CNT_W'(`NS_TO_CYC(`T_CPUV_BLANK_NS));
    localparam logic [`CNT_W-1:0] BLK1_CYC  = `CNT_W'(`NS_TO_CYC(`T_BLK_BRAKE1_NS));
    localparam logic [`CNT_W-1:0] BLK2_CYC  = `CNT_W'(`NS_TO_CYC(`T_BLK_BRAKE2_NS));
    localparam logic [`CNT_W-1:0] FVDS_CYC  = `CNT_W'(`NS_TO_CYC(`T_FVDS_BRAKE_NS));
    localparam logic [`CNT_W-1:0] OVF_CYC   = `CNT_W'(`NS_TO_CYC(`T_OV_FILT_NS));

    // Every pin passes two flops; logic reads the second stage, plus a third flop on supply recovery for edge detection
    logic [`SYNC_W-1:0] sync1_ff;
    logic [`SYNC_W-1:0] sync2_ff;
    logic               recov_d_ff;
    wire  [`SYNC_W-1:0] raw_in = {gates_on_i, supply_recovery_i, low_power_mode_i, pwm_input_pin_i,
                                  internal_ov_low_i, supply_ov_low_i, internal_ov_cmp_i,
                                  supply_ov_cmp_i, lowside_vds_cmp_i, pump_uv_cmp_i};

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            sync1_ff   <= `SYNC_W'h0;
            sync2_ff   <= `SYNC_W'h0;
            recov_d_ff <= 1'b0;
        end
        else
        begin
            sync1_ff   <= raw_in;
            sync2_ff   <= sync1_ff;
            recov_d_ff <= sync2_ff[9];
        end
    end

    wire       uv_s       = sync2_ff[0];
    wire [1:0] vds_s      = sync2_ff[2:1];
    wire       vs_ov_s    = sync2_ff[3];
    wire       vsint_ov_s = sync2_ff[4];
    wire       vs_low_s   = sync2_ff[5];
    wire       vsint_lo_s = sync2_ff[6];
    wire       pwm_s      = sync2_ff[7];
    wire       lowpwr_s   = sync2_ff[8];
    wire       recov_evt  = sync2_ff[9] & ~recov_d_ff;
    wire       gates_on_s = sync2_ff[10];

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [`CTRL_W-1:0] ctrl_ff;
    logic               cpuv_flag_ff;
    logic               cpuv_clr_req_ff;
    logic [`FLT_W-1:0]  flt_ff;
    logic [`IRQ_W-1:0]  irq_stat_ff;
    logic [`IRQ_W-1:0]  irq_mask_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    wire wr_ctrl = wr_i & hit(addr_i, `ADDR_CTRL);
    wire wr_sup  = wr_i & hit(addr_i, `ADDR_SUP_STAT);
    wire wr_flt  = wr_i & hit(addr_i, `ADDR_DS_FAULT);
    wire wr_istat = wr_i & hit(addr_i, `ADDR_IRQ_STAT);
    wire wr_imask = wr_i & hit(addr_i, `ADDR_IRQ_MASK);

    wire       pump_en_bit = ctrl_ff[`CTRL_PUMP_EN];
    wire       ovbrk_en    = ctrl_ff[`CTRL_OVBRK_EN];
    wire [1:0] slam_dis    = ctrl_ff[`CTRL_SLAM_DIS +: 2];
    wire       any_ls_flt  = |flt_ff[`FLT_LS +: 2];

    // Measurement words pack {t_on_delay, t_off_delay, t_rise, t_fall}, 8 bits each
    wire [31:0] meas_sel = ctrl_ff[`CTRL_CHECK_SEL] ? meas_active_i : meas_pwm_i;  // [RL6]

    ////////////////////////////////////////////////////////////////////////////
    // Charge pump supervision

    gds_pkg::pump_state_t pump_st_ff;
    gds_pkg::pump_state_t nxt_pump_st;
    logic [`CNT_W-1:0]    pump_cnt_ff;
    logic [`CNT_W-1:0]    nxt_pump_cnt;

    // Enable write is always stored; braking faults only hold the pump off
    wire pump_req = pump_en_bit & ~any_ls_flt;  // [RL13]
    // Detection only counts in RUN, so blanking masks it by construction
    wire cpuv_set = (pump_st_ff == gds_pkg::PUMP_RUN) & uv_s;

    always_comb
    begin
        nxt_pump_st  = pump_st_ff;
        nxt_pump_cnt = (pump_cnt_ff != `CNT_W'h0) ? pump_cnt_ff - `CNT_W'h1 : pump_cnt_ff;
        case (pump_st_ff)
            gds_pkg::PUMP_OFF:
            begin
                if (pump_req)
                begin
                    nxt_pump_st  = gds_pkg::PUMP_BLANK;
                    nxt_pump_cnt = CPUV_CYC;  // [RL5]
                end
            end
            gds_pkg::PUMP_BLANK:
            begin
                if (!pump_req)
                    nxt_pump_st = gds_pkg::PUMP_OFF;
                else if (recov_evt)
                    nxt_pump_cnt = CPUV_CYC;  // [RL5]
                else if (pump_cnt_ff <= `CNT_W'h1)
                    nxt_pump_st = gds_pkg::PUMP_RUN;
            end
            gds_pkg::PUMP_RUN:
            begin
                if (!pump_req)
                    nxt_pump_st = gds_pkg::PUMP_OFF;
                else if (recov_evt)
                begin
                    nxt_pump_st  = gds_pkg::PUMP_BLANK;
                    nxt_pump_cnt = CPUV_CYC;  // [RL5]
                end
                else if (uv_s)
                begin
                    nxt_pump_st  = gates_on_s ? gds_pkg::PUMP_DISCHARGE : gds_pkg::PUMP_FAULT;  // [RL2]
                    nxt_pump_cnt = CCP_CYC;  // [RL2]
                end
            end
            gds_pkg::PUMP_DISCHARGE:
            begin
                if (pump_cnt_ff <= `CNT_W'h1)
                    nxt_pump_st = gds_pkg::PUMP_FAULT;  // [RL3]
            end
            gds_pkg::PUMP_FAULT:
            begin
                if (!cpuv_flag_ff && !uv_s)
                    nxt_pump_st = pump_req ? gds_pkg::PUMP_RUN : gds_pkg::PUMP_OFF;  // [RL4]
            end
            default:
                nxt_pump_st = gds_pkg::PUMP_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            pump_st_ff  <= gds_pkg::PUMP_OFF;
            pump_cnt_ff <= `CNT_W'h0;
        end
        else
        begin
            pump_st_ff  <= nxt_pump_st;
            pump_cnt_ff <= nxt_pump_cnt;
        end
    end

    // Clear request waits for the pump to come back above its threshold
    wire cpuv_clear = cpuv_clr_req_ff & ~uv_s;  // [RL4]
    wire pump_live  = (pump_st_ff != gds_pkg::PUMP_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Braking

    // Overvoltage is latched even with braking disabled; the enable bit
    // gates its effect on the low-sides and on the supply fault flags
    logic              ov_hold_ff;
    logic [`CNT_W-1:0] ovf_cnt_ff;
    logic              brake_d_ff;
    logic [`CNT_W-1:0] blk_cnt_ff;

    wire ov_any    = vs_ov_s | vsint_ov_s;
    wire both_low  = vs_low_s & vsint_lo_s;
    wire ov_brake  = ovbrk_en & ov_hold_ff;  // [RL14]
    wire slam_act  = ctrl_ff[`CTRL_SLAM_EN] & pwm_s & ~pump_live;  // [RL7]
    wire park_act  = ctrl_ff[`CTRL_PARK_EN] & lowpwr_s & ~pump_live;  // [RL7]
    wire brake_on  = slam_act | park_act | ov_brake;
    wire brake_go  = brake_on & ~brake_d_ff;
    wire blank_end = (blk_cnt_ff == `CNT_W'h0);

    // Overvoltage turns all sides on; sudden-stop honours per-side disable
    wire [1:0] ls_demand = (ov_brake | park_act) ? 2'h3 : (slam_act ? ~slam_dis : 2'h0);  // [RL15]

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            ov_hold_ff <= 1'b0;
            ovf_cnt_ff <= `CNT_W'h0;
        end
        else if (ov_any)
        begin
            ov_hold_ff <= 1'b1;  // [RL15]
            ovf_cnt_ff <= OVF_CYC;
        end
        else if (ov_hold_ff && both_low)
        begin
            ovf_cnt_ff <= ovf_cnt_ff - `CNT_W'h1;
            if (ovf_cnt_ff <= `CNT_W'h1)
                ov_hold_ff <= 1'b0;  // [RL16]
        end
        else
            ovf_cnt_ff <= OVF_CYC;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            brake_d_ff <= 1'b0;
            blk_cnt_ff <= `CNT_W'h0;
        end
        else
        begin
            brake_d_ff <= brake_on;
            if (brake_go)
                blk_cnt_ff <= ctrl_ff[`CTRL_BRK_BLK] ? BLK2_CYC : BLK1_CYC;  // [RL9]
            else if (!blank_end)
                blk_cnt_ff <= blk_cnt_ff - `CNT_W'h1;
        end
    end

    // One filter per low-side; a trip on either one turns both off
    logic [1:0] vds_trip;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_ls
            logic [`CNT_W-1:0] filt_cnt_ff;
            // Comparator already runs at the threshold chosen by brake_threshold_o
            wire watch = brake_on & blank_end & lowside_on_o[g] & vds_s[g];  // [RL9] [RL8]

            always_ff @(posedge core_clk_i)
            begin
                if (!resetn_i || !watch)
                    filt_cnt_ff <= FVDS_CYC;
                else if (filt_cnt_ff != `CNT_W'h0)
                    filt_cnt_ff <= filt_cnt_ff - `CNT_W'h1;
            end

            assign vds_trip[g] = watch & (filt_cnt_ff <= `CNT_W'h1);  // [RL10] [RL17]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Status, interrupt and control registers

    wire [`FLT_W-1:0] flt_set = {ov_brake & vsint_ov_s, ov_brake & vs_ov_s, vds_trip};  // [RL11] [RL15]
    wire [`IRQ_W-1:0] irq_evt = {flt_set[`FLT_VSINT] & ~flt_ff[`FLT_VSINT],
                                 flt_set[`FLT_VS] & ~flt_ff[`FLT_VS], |vds_trip, cpuv_set};

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            ctrl_ff         <= `CTRL_RESET;
            cpuv_flag_ff    <= 1'b0;
            cpuv_clr_req_ff <= 1'b0;
            flt_ff          <= `FLT_W'h0;
            irq_stat_ff     <= `IRQ_W'h0;
            irq_mask_ff     <= `IRQ_W'h0;
        end
        else
        begin
            // Faults never touch ctrl_ff, so braking setup survives a trip
            if (wr_ctrl)
                ctrl_ff <= wdata_i[`CTRL_W-1:0];  // [RL11]
            cpuv_flag_ff    <= cpuv_set | (cpuv_flag_ff & ~cpuv_clear);  // [RL3]
            cpuv_clr_req_ff <= ~cpuv_set & ((wr_sup & wdata_i[0]) | (cpuv_clr_req_ff & ~cpuv_clear));
            flt_ff          <= flt_set | (flt_ff & ~({`FLT_W{wr_flt}} & wdata_i[`FLT_W-1:0]));
            irq_stat_ff     <= irq_evt | (irq_stat_ff & ~({`IRQ_W{wr_istat}} & wdata_i[`IRQ_W-1:0]));
            if (wr_imask)
                irq_mask_ff <= wdata_i[`IRQ_W-1:0];
        end
    end

    // Read data is zero outside the cycle after a read strobe
    wire [31:0] rd_mux =
        hit(addr_i, `ADDR_CTRL)      ? {21'h0, ctrl_ff} :
        hit(addr_i, `ADDR_SUP_STAT)  ? {31'h0, cpuv_flag_ff} :
        hit(addr_i, `ADDR_DS_FAULT)  ? {28'h0, flt_ff} :
        hit(addr_i, `ADDR_IRQ_STAT)  ? {28'h0, irq_stat_ff} :
        hit(addr_i, `ADDR_IRQ_MASK)  ? {28'h0, irq_mask_ff} :
        hit(addr_i, `ADDR_DELAY_REP) ? {16'h0, meas_sel[31:16]} :  // [RL6]
        hit(addr_i, `ADDR_EDGE_REP)  ? {16'h0, meas_sel[15:0]} :  // [RL6]
        hit(addr_i, `ADDR_STATE)     ? {24'h0, brake_on, ~blank_end, lowside_on_o, 1'b0, pump_st_ff} :
        32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Fault gating comes last so no braking source can override a latched trip
    wire [1:0] nxt_ls_on = (any_ls_flt | (|vds_trip)) ? 2'h0 : ls_demand;  // [RL11] [RL12] [RL7]

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            rdata_o           <= 32'h0;
            pump_uv_level_o   <= 2'h0;
            pump_on_o         <= 1'b0;
            active_off_o      <= 1'b0;
            drivers_enable_o  <= 1'b0;
            lowside_on_o      <= 2'h0;
            brake_threshold_o <= 1'b0;
            ov_brake_config_o <= 3'h0;
            irq_o             <= 1'b0;
        end
        else
        begin
            rdata_o           <= rd_i ? rd_mux : 32'h0;
            pump_uv_level_o   <= {ctrl_ff[`CTRL_MOSFET_LEVEL_SELECT], ctrl_ff[`CTRL_UVTH]};  // [RL1]
            pump_on_o         <= (nxt_pump_st != gds_pkg::PUMP_OFF);  // [RL13]
            active_off_o      <= (nxt_pump_st == gds_pkg::PUMP_DISCHARGE);  // [RL2]
            drivers_enable_o  <= (nxt_pump_st == gds_pkg::PUMP_RUN) || (nxt_pump_st == gds_pkg::PUMP_BLANK);  // [RL3]
            lowside_on_o      <= nxt_ls_on;
            brake_threshold_o <= ctrl_ff[`CTRL_BRK_TH];  // [RL8]
            ov_brake_config_o <= wr_ctrl ? 3'h0 : 3'h0;
            irq_o             <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule

// File: rtl/gds_params.svh
`ifndef GDS_PARAMS_SVH
`define GDS_PARAMS_SVH

`define CLK_PERIOD_NS   100
`define NS_TO_CYC(t)    ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                         (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// Durations in ns
`define T_CCP_NS        2000
`define T_CPUV_BLANK_NS 10000
`define T_BLK_BRAKE1_NS 2000
`define T_BLK_BRAKE2_NS 8000
`define T_FVDS_BRAKE_NS 3000
`define T_OV_FILT_NS    50000

`define CNT_W           10
`define SYNC_W          11

// Register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_SUP_STAT   8'h04
`define ADDR_DS_FAULT   8'h08
`define ADDR_IRQ_STAT   8'h0c
`define ADDR_IRQ_MASK   8'h10
`define ADDR_DELAY_REP  8'h14
`define ADDR_EDGE_REP   8'h18
`define ADDR_STATE      8'h1c

// Control register fields
`define CTRL_PUMP_EN    0
`define CTRL_MOSFET_LEVEL_SELECT    1
`define CTRL_UVTH       2
`define CTRL_CHECK_SEL  3
`define CTRL_OVBRK_EN   4
`define CTRL_BRK_TH     5
`define CTRL_BRK_BLK    6
`define CTRL_PARK_EN    7
`define CTRL_SLAM_EN    8
`define CTRL_SLAM_DIS   9
`define CTRL_W          11
`define CTRL_RESET      11'h000

// Fault register fields
`define FLT_LS          0
`define FLT_VS          2
`define FLT_VSINT       3
`define FLT_W           4

// Interrupt status fields
`define IRQ_CPUV        0
`define IRQ_LSFLT       1
`define IRQ_VSBRK       2
`define IRQ_VSINTBRK    3
`define IRQ_W           4

`endif

// File: rtl/gds_pkg.sv
package gds_pkg;
    typedef enum logic [2:0] {
        PUMP_OFF,
        PUMP_BLANK,
        PUMP_RUN,
        PUMP_DISCHARGE,
        PUMP_FAULT
    } pump_state_t;
endpackage

// File: verif/gds_assertions.sv
module gds_assertions (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0]  pump_uv_level_o,
    input wire logic        pump_on_o,
    input wire logic        active_off_o,
    input wire logic        drivers_enable_o,
    input wire logic        brake_threshold_o,
    input wire logic [2:0]  ov_brake_config_o,
    input wire logic        irq_o
);
    logic [10:0] ctrl_ff;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Shadow of the control word, so readback and level outputs can be judged
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            ctrl_ff <= 11'h000;
        else if (wr_i && addr_i == 8'h00)
            ctrl_ff <= wdata_i[10:0];
    end

    rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not idle");
    ctrl_back_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == {21'h0, $past(ctrl_ff)})
        else $error("control readback wrong");
    unmapped_zero_a: assert property (rd_i && addr_i == 8'h20 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    ov_cfg_a: assert property (ov_brake_config_o == 3'h0)
        else $error("brake config not zero");
    uv_level_a: assert property ($stable(ctrl_ff) [*3] |-> pump_uv_level_o == {ctrl_ff[1], ctrl_ff[2]})
        else $error("pump threshold select wrong");
    brk_thr_a: assert property (!$past(wr_i) && !$past(wr_i, 2) |-> brake_threshold_o == ctrl_ff[5])
        else $error("brake threshold select wrong");
    irq_mask_a: assert property (wr_i && addr_i == 8'h10 && wdata_i[3:0] == 4'h0 |-> ##[1:3] !irq_o)
        else $error("masked interrupt still high");
    discharge_len_a: assert property ($rose(active_off_o) |=> active_off_o [*8])
        else $error("active discharge too short");
    drivers_off_a: assert property ($fell(active_off_o) |-> ##[0:2] !drivers_enable_o)
        else $error("drivers not off after discharge");
    pump_blank_a: assert property ($rose(pump_on_o) |-> !active_off_o [*8])
        else $error("undervoltage not blanked");
endmodule

bind gate_driver_fault_supervisor gds_assertions i_gds_assertions (
    .core_clk_i       (core_clk_i),
    .resetn_i         (resetn_i),
    .addr_i           (addr_i),
    .wdata_i          (wdata_i),
    .wr_i             (wr_i),
    .rd_i             (rd_i),
    .rdata_o          (rdata_o),
    .pump_uv_level_o  (pump_uv_level_o),
    .pump_on_o        (pump_on_o),
    .active_off_o     (active_off_o),
    .drivers_enable_o (drivers_enable_o),
    .brake_threshold_o(brake_threshold_o),
    .ov_brake_config_o(ov_brake_config_o),
    .irq_o            (irq_o)
);

// File: verif/gds_bridge_model.sv
module gds_bridge_model (
    input  wire logic [1:0] gate_cmd_i,
    input  wire logic [1:0] short_i,
    input  wire logic       high_side_on_i,
    output logic      [1:0] vds_high_o,
    output logic            any_gate_on_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A shorted low-side only shows excess drain-source voltage while driven on
    assign vds_high_o    = gate_cmd_i & short_i;
    assign any_gate_on_o = |gate_cmd_i || high_side_on_i;
endmodule

// File: verif/gate_driver_fault_supervisor_test.sv
module gate_driver_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i, resetn_i, wr_i, rd_i, pump_uv_cmp_i, supply_ov_cmp_i, internal_ov_cmp_i;
    logic        supply_ov_low_i, internal_ov_low_i, pwm_input_pin_i, low_power_mode_i, gates_on_i, hs_on, recov;
    logic        pump_on_o, active_off_o, drivers_enable_o, brake_threshold_o, irq_o;
    logic [1:0]  lowside_vds_cmp_i, short_ls, lowside_on_o, pump_uv_level_o;
    logic [2:0]  ov_brake_config_o;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, meas_active_i, meas_pwm_i, got, seed;
    int          num_errors, checks_done, cycles, i, k, n, ctrl_m, blank;

    gate_driver_fault_supervisor i_gate_driver_fault_supervisor (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pump_uv_cmp_i(pump_uv_cmp_i), .lowside_vds_cmp_i(lowside_vds_cmp_i), .supply_ov_cmp_i(supply_ov_cmp_i),
        .internal_ov_cmp_i(internal_ov_cmp_i), .supply_ov_low_i(supply_ov_low_i),
        .internal_ov_low_i(internal_ov_low_i), .pwm_input_pin_i(pwm_input_pin_i),
        .low_power_mode_i(low_power_mode_i), .supply_recovery_i(recov), .gates_on_i(gates_on_i),
        .meas_active_i(meas_active_i), .meas_pwm_i(meas_pwm_i), .pump_uv_level_o(pump_uv_level_o),
        .pump_on_o(pump_on_o), .active_off_o(active_off_o), .drivers_enable_o(drivers_enable_o),
        .lowside_on_o(lowside_on_o), .brake_threshold_o(brake_threshold_o),
        .ov_brake_config_o(ov_brake_config_o), .irq_o(irq_o));

    gds_bridge_model i_gds_bridge_model (.gate_cmd_i(lowside_on_o), .short_i(short_ls), .high_side_on_i(hs_on),
        .vds_high_o(lowside_vds_cmp_i), .any_gate_on_o(gates_on_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Every driver starts at an edge, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input int d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input int e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk(rdata_o, e);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
    begin
        pwm_input_pin_i <= $random(seed);
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    initial
    begin
        seed = 32'h859b9321;
        {resetn_i, wr_i, rd_i, addr_i, wdata_i, pump_uv_cmp_i, supply_ov_cmp_i, internal_ov_cmp_i} = '0;
        {pwm_input_pin_i, low_power_mode_i, hs_on, short_ls, recov} = '0;
        supply_ov_low_i = 1'b1;
        internal_ov_low_i = 1'b1;
        meas_active_i = $random(seed);
        meas_pwm_i = $random(seed);
        repeat (8) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rchk(8'h00, 0);
        rchk(8'h20, 0);
        for (k = 0; k < 16; k++)
        begin
            ctrl_m = (k & 7) << 1 | (k >> 3) << 5;
            wr(8'h00, ctrl_m);
            cyc(3);
            chk(pump_uv_level_o, {k[0], k[1]});
            chk(brake_threshold_o, k[3]);
            rchk(8'h00, ctrl_m);
            rchk(8'h14, (k[2] ? meas_active_i : meas_pwm_i) >> 16);
            rchk(8'h18, (k[2] ? meas_active_i : meas_pwm_i) & 32'hffff);
        end
        // Pump undervoltage with a high-side on: blank, discharge, latch, recovery
        @(posedge core_clk_i);
        hs_on <= 1'b1;
        wr(8'h00, 1);
        pump_uv_cmp_i <= 1'b1;
        cyc(80);
        chk(active_off_o, 0);
        for (i = 0; i < 80 && !active_off_o; i++) @(negedge core_clk_i);
        for (n = 0; n < 60 && active_off_o; n++) @(negedge core_clk_i);
        chk(n, 20);
        cyc(2);
        chk(drivers_enable_o, 0);
        rchk(8'h04, 1);
        wr(8'h10, 1);
        cyc(3);
        chk(irq_o, 1);
        wr(8'h04, 1);
        cyc(5);
        rchk(8'h04, 1);
        @(posedge core_clk_i);
        pump_uv_cmp_i <= 1'b0;
        wr(8'h04, 1);
        cyc(5);
        rchk(8'h04, 0);
        for (i = 0; i < 150 && drivers_enable_o !== 1'b1; i++) @(negedge core_clk_i);
        chk(drivers_enable_o, 1);
        @(posedge core_clk_i);
        recov <= 1'b1;
        cyc(4);
        rchk(8'h1c, 1);
        wr(8'h0c, 15);
        wr(8'h10, 0);
        wr(8'h00, 0);
        cyc(3);
        chk(irq_o, 0);
        @(posedge core_clk_i);
        hs_on <= 1'b0;
        // Parking brake with low-side 0 shorted, both blank lengths
        for (k = 0; k < 2; k++)
        begin
            blank = k ? 80 : 20;
            ctrl_m = 1 << 7 | k << 6;
            wr(8'h00, ctrl_m);
            low_power_mode_i <= 1'b1;
            short_ls <= 2'b01;
            for (i = 0; i < 20 && lowside_on_o !== 2'b11; i++) @(negedge core_clk_i);
            chk(lowside_on_o, 3);
            cyc(blank - 4);
            chk(lowside_on_o, 3);
            cyc(20);
            chk(lowside_on_o, 3);
            cyc(40);
            chk(lowside_on_o, 0);
            @(posedge core_clk_i);
            short_ls <= 2'b00;
            rchk(8'h08, 1);
            rchk(8'h00, ctrl_m);
            wr(8'h00, ctrl_m | 1);
            cyc(10);
            chk(pump_on_o, 0);
            chk(lowside_on_o, 0);
            wr(8'h00, ctrl_m);
            wr(8'h08, 3);
            for (i = 0; i < 30 && lowside_on_o !== 2'b11; i++) @(negedge core_clk_i);
            chk(lowside_on_o, 3);
            @(posedge core_clk_i);
            low_power_mode_i <= 1'b0;
            wr(8'h0c, 15);
        end
        // Overvoltage braking from the supply in normal mode, then from the internal supply in low-power mode
        for (k = 0; k < 2; k++)
        begin
            wr(8'h00, 1 << 4);
            {internal_ov_cmp_i, supply_ov_cmp_i} <= k ? 2'b10 : 2'b01;
            {supply_ov_low_i, internal_ov_low_i, low_power_mode_i} <= {2'b00, k[0]};
            for (i = 0; i < 10 && lowside_on_o !== 2'b11; i++) @(negedge core_clk_i);
            chk(lowside_on_o, 3);
            rchk(8'h08, k ? 8 : 4);
            @(posedge core_clk_i);
            {internal_ov_cmp_i, supply_ov_cmp_i, supply_ov_low_i, internal_ov_low_i} <= 4'h3;
            cyc(400);
            chk(lowside_on_o, 3);
            for (i = 0; i < 150 && lowside_on_o !== 2'b00; i++) @(negedge core_clk_i);
            chk(lowside_on_o, 0);
            wr(8'h08, 12);
            wr(8'h0c, 15);
        end
        // Low-side 1 shorted while overvoltage braking holds both sides on
        wr(8'h00, 1 << 4);
        {supply_ov_cmp_i, supply_ov_low_i, short_ls} <= 4'b1010;
        for (i = 0; i < 10 && lowside_on_o !== 2'b11; i++) @(negedge core_clk_i);
        cyc(60);
        chk(lowside_on_o, 0);
        rchk(8'h08, 6);
        end_of_test();
    end
endmodule
